// ===== hw/dsc_consts.vh
// Constants for the DDR graphics DRAM command-state block.
// Assumes a 100 MHz command clock; included by bare name.
//
// What this block does
// - Precharge closes the bank's row; bank reopens only after row-precharge time.
// - All-banks bit picks one bank or all; bank bits ignored for all.
// - Clock enable low with no access enters precharge or active power-down.
// - Power-down disables input and output buffers except clock and clock enable.
// - Power-down exits on clock enable high with NOP or deselect.
// - Clock-enable transitions from previous and current samples pick low-power state.
// - Clock-enable state is samples n-1 and n; command acts at edge n.
// - Deselect and NOP leave the ongoing operation unchanged in every state.
// - Strobes decode to active, refresh, mode set, read, write, precharge, terminate.
// - Open idle row accepts read, write and precharge.
// - Read burst accepts read, terminate, and precharge that truncates it.
// - Write burst accepts write, read, and precharge that truncates it.
// - Same-bank table applies only with clock enable high twice, after exit time.
// - States and sequences outside the tables are illegal; the block flags them on cmd_illegal_r.
// - Burst terminate acts on the latest read burst, whatever its bank.
`ifndef DSC_CONSTS_VH
`define DSC_CONSTS_VH

`define DSC_CLK_NS 10
`define DSC_T_RP_NS 20
`define DSC_T_RCD_NS 20
`define DSC_T_RFC_NS 70
`define DSC_T_MRD_NS 10
`define DSC_T_XSNR_NS 80
`define DSC_RP_CYC ((`DSC_T_RP_NS + `DSC_CLK_NS - 1) / `DSC_CLK_NS)
`define DSC_RCD_CYC ((`DSC_T_RCD_NS + `DSC_CLK_NS - 1) / `DSC_CLK_NS)
`define DSC_RFC_CYC ((`DSC_T_RFC_NS + `DSC_CLK_NS - 1) / `DSC_CLK_NS)
`define DSC_MRD_CYC ((`DSC_T_MRD_NS + `DSC_CLK_NS - 1) / `DSC_CLK_NS)
`define DSC_XSNR_CYC ((`DSC_T_XSNR_NS + `DSC_CLK_NS - 1) / `DSC_CLK_NS)
`define DSC_DLL_CYC 200
`define DSC_BURST_CYC 2

// Decoded commands
`define DSC_CMD_DES 4'h0
`define DSC_CMD_NOP 4'h1
`define DSC_CMD_ACT 4'h2
`define DSC_CMD_RD 4'h3
`define DSC_CMD_WR 4'h4
`define DSC_CMD_PRE 4'h5
`define DSC_CMD_BST 4'h6
`define DSC_CMD_REF 4'h7
`define DSC_CMD_MRS 4'h8

// Bank states
`define DSC_BK_IDLE 3'h0
`define DSC_BK_ACTG 3'h1
`define DSC_BK_ACTIVE 3'h2
`define DSC_BK_READ 3'h3
`define DSC_BK_WRITE 3'h4
`define DSC_BK_PRECH 3'h5
`define DSC_BK_READ_AP 3'h6
`define DSC_BK_WRITE_AP 3'h7

// Low-power state codes on the output
`define DSC_LP_NONE 2'h0
`define DSC_LP_PPD 2'h1
`define DSC_LP_APD 2'h2
`define DSC_LP_SREF 2'h3

`endif

// ===== hw/dsc_cmd_dec.v
// Decodes chip select and the three strobes into a command code.
// Pure combinational; inputs are sampled by the caller.
`timescale 1ns/1ps
`include "dsc_consts.vh"

module dsc_cmd_dec
(
   input wire cs_n,
   input wire ras_n,
   input wire cas_n,
   input wire we_n,
   output reg [3:0] cmd
);

   always @*
   begin
      if (cs_n)
      begin
         cmd = `DSC_CMD_DES;
      end
      else
      begin
         case ({ras_n, cas_n, we_n})
            3'h7: cmd = `DSC_CMD_NOP;
            3'h3: cmd = `DSC_CMD_ACT;
            3'h1: cmd = `DSC_CMD_REF;
            3'h0: cmd = `DSC_CMD_MRS;
            3'h5: cmd = `DSC_CMD_RD;
            3'h4: cmd = `DSC_CMD_WR;
            3'h2: cmd = `DSC_CMD_PRE;
            3'h6: cmd = `DSC_CMD_BST;
            default: cmd = `DSC_CMD_NOP;
         endcase
      end
   end

endmodule

// ===== hw/dsc_wait_cnt.v
// Loadable down-counter for timing waits.
// Load value 0 clears it; busy while nonzero, expire on the last cycle.
`timescale 1ns/1ps

module dsc_wait_cnt
(
   input wire mclk,
   input wire srst,
   input wire load,
   input wire [7:0] load_val,
   output wire busy,
   output wire expire
);

   reg [7:0] cnt_r;

   always @(posedge mclk)
   begin
      if (srst)
         cnt_r <= 8'h00;
      else if (load)
         cnt_r <= load_val;
      else if (cnt_r != 8'h00)
         cnt_r <= cnt_r - 8'h01;
   end

   assign busy = (cnt_r != 8'h00);
   assign expire = (cnt_r == 8'h01);

endmodule

// ===== hw/dsc_cmd_state.v
// Command-state logic of a four-bank DDR graphics DRAM.
// Commands and clock enable are synchronous to mclk; the controller
// drives them and is expected to keep its own timing waits.
`timescale 1ns/1ps
`include "dsc_consts.vh"

module dsc_cmd_state
(
   input wire mclk,
   input wire srst,
   input wire cke,
   input wire cs_n,
   input wire ras_n,
   input wire cas_n,
   input wire we_n,
   input wire all_banks_select_bit,
   input wire bank_select_bit0,
   input wire bank_select_bit1,
   input wire dll_en,
   output wire [11:0] bank_state,
   output reg [1:0] lp_state_r,
   output reg buf_en_r,
   output reg cmd_illegal_r,
   output reg dll_ready_r,
   output reg [1:0] last_rd_bank_r
);

   localparam G_RUN = 3'h0;
   localparam G_REF = 3'h1;
   localparam G_MRS = 3'h2;
   localparam G_PPD = 3'h3;
   localparam G_APD = 3'h4;
   localparam G_SREF = 3'h5;
   localparam G_XSR = 3'h6;

   localparam [7:0] RP_LD = `DSC_RP_CYC;
   localparam [7:0] RCD_LD = `DSC_RCD_CYC;
   localparam [7:0] RFC_LD = `DSC_RFC_CYC;
   localparam [7:0] MRD_LD = `DSC_MRD_CYC;
   localparam [7:0] XSNR_LD = `DSC_XSNR_CYC;
   localparam [7:0] DLL_LD = `DSC_DLL_CYC;
   localparam [7:0] BURST_LD = `DSC_BURST_CYC;

   wire [3:0] cmd;
   wire [1:0] bank_sel;
   wire is_nop;
   wire tbl_en;
   wire [3:0] bk_idle;
   wire [3:0] bk_open;
   wire [3:0] bk_ill;
   wire [3:0] bk_rd;
   wire all_idle;
   wire no_access;
   wire g_busy;
   wire g_expire;
   wire dll_busy;
   wire dll_expire;

   reg [2:0] g_r;
   reg [2:0] g_nxt;
   reg cke_prev_r;
   reg dll_en_prev_r;
   reg g_load;
   reg [7:0] g_load_val;
   reg g_ill;
   reg dll_load;

   dsc_cmd_dec u_dec
   (
      .cs_n(cs_n),
      .ras_n(ras_n),
      .cas_n(cas_n),
      .we_n(we_n),
      .cmd(cmd)
   );

   assign bank_sel = {bank_select_bit1, bank_select_bit0};
   assign is_nop = (cmd == `DSC_CMD_DES) || (cmd == `DSC_CMD_NOP);
   // Table only with enable high at n-1 and n, normal state
   assign tbl_en = cke_prev_r && cke && (g_r == G_RUN);
   assign all_idle = &bk_idle;
   assign no_access = &(bk_idle | bk_open);

   genvar i;
   generate
      for (i = 0; i < 4; i = i + 1)
      begin : g_bank
         reg [2:0] st_r;
         reg [2:0] st_nxt;
         reg ld;
         reg [7:0] ldv;
         reg ill;
         wire t_busy;
         wire t_expire;
         wire hit;
         wire hit_pre;

         dsc_wait_cnt u_tmr
         (
            .mclk(mclk),
            .srst(srst),
            .load(ld),
            .load_val(ldv),
            .busy(t_busy),
            .expire(t_expire)
         );

         assign hit = (bank_sel == i);
         assign hit_pre = all_banks_select_bit || hit;

         always @*
         begin
            st_nxt = st_r;
            ld = 1'b0;
            ldv = 8'h00;
            ill = 1'b0;
            if (tbl_en)
            begin
               case (cmd)
                  `DSC_CMD_ACT:
                  begin
                     if (hit)
                     begin
                        if (st_r == `DSC_BK_IDLE)
                        begin
                           st_nxt = `DSC_BK_ACTG;
                           ld = 1'b1;
                           ldv = RCD_LD;
                        end
                        else
                           ill = 1'b1;
                     end
                  end
                  `DSC_CMD_RD, `DSC_CMD_WR:
                  begin
                     if (hit)
                     begin
                        // Write may not cut into a read burst
                        if (st_r == `DSC_BK_ACTIVE ||
                            st_r == `DSC_BK_WRITE ||
                            (st_r == `DSC_BK_READ &&
                             cmd == `DSC_CMD_RD))
                        begin
                           ld = 1'b1;
                           ldv = BURST_LD;
                           if (cmd == `DSC_CMD_RD)
                              st_nxt = all_banks_select_bit ?
                                 `DSC_BK_READ_AP : `DSC_BK_READ;
                           else
                              st_nxt = all_banks_select_bit ?
                                 `DSC_BK_WRITE_AP : `DSC_BK_WRITE;
                        end
                        else
                           ill = 1'b1;
                     end
                  end
                  `DSC_CMD_PRE:
                  begin
                     if (hit_pre)
                     begin
                        // Precharge truncates a running burst; auto-precharge bursts flag it illegal
                        if (st_r == `DSC_BK_ACTIVE ||
                            st_r == `DSC_BK_READ ||
                            st_r == `DSC_BK_WRITE)
                        begin
                           st_nxt = `DSC_BK_PRECH;
                           ld = 1'b1;
                           ldv = RP_LD;
                        end
                        else if (st_r != `DSC_BK_IDLE)
                           ill = 1'b1;
                     end
                  end
                  `DSC_CMD_BST:
                  begin
                     if (last_rd_bank_r == i)
                     begin
                        if (st_r == `DSC_BK_READ)
                        begin
                           st_nxt = `DSC_BK_ACTIVE;
                           ld = 1'b1;
                           ldv = 8'h00;
                        end
                        else
                           ill = 1'b1;
                     end
                  end
                  default: st_nxt = st_r;
               endcase
            end
            if (!ld && t_expire)
            begin
               case (st_r)
                  `DSC_BK_ACTG: st_nxt = `DSC_BK_ACTIVE;
                  `DSC_BK_PRECH: st_nxt = `DSC_BK_IDLE;
                  `DSC_BK_READ: st_nxt = `DSC_BK_ACTIVE;
                  `DSC_BK_WRITE: st_nxt = `DSC_BK_ACTIVE;
                  `DSC_BK_READ_AP, `DSC_BK_WRITE_AP:
                  begin
                     st_nxt = `DSC_BK_PRECH;
                     ld = 1'b1;
                     ldv = RP_LD;
                  end
                  default: st_nxt = st_r;
               endcase
            end
         end

         always @(posedge mclk)
         begin
            if (srst)
               st_r <= `DSC_BK_IDLE;
            else
               st_r <= st_nxt;
         end

         assign bank_state[3*i+2:3*i] = st_r;
         assign bk_idle[i] = (st_r == `DSC_BK_IDLE) && !t_busy;
         assign bk_open[i] = (st_r == `DSC_BK_ACTIVE);
         assign bk_ill[i] = ill;
         assign bk_rd[i] = tbl_en && (cmd == `DSC_CMD_RD) && hit && !ill;
      end
   endgenerate

   dsc_wait_cnt u_gtmr
   (
      .mclk(mclk),
      .srst(srst),
      .load(g_load),
      .load_val(g_load_val),
      .busy(g_busy),
      .expire(g_expire)
   );

   dsc_wait_cnt u_dll
   (
      .mclk(mclk),
      .srst(srst),
      .load(dll_load),
      .load_val(DLL_LD),
      .busy(dll_busy),
      .expire(dll_expire)
   );

   always @*
   begin
      g_nxt = g_r;
      g_load = 1'b0;
      g_load_val = 8'h00;
      g_ill = 1'b0;
      dll_load = dll_en && !dll_en_prev_r;
      case (g_r)
         G_RUN:
         begin
            if (cke_prev_r && !cke)
            begin
               if (all_idle && is_nop)
                  g_nxt = G_PPD;
               else if (all_idle && cmd == `DSC_CMD_REF)
                  g_nxt = G_SREF;
               else if (no_access && is_nop)
                  g_nxt = G_APD;
               else
                  g_ill = 1'b1;
            end
            else if (tbl_en)
            begin
               if (cmd == `DSC_CMD_REF || cmd == `DSC_CMD_MRS)
               begin
                  if (all_idle)
                  begin
                     g_nxt = (cmd == `DSC_CMD_REF) ? G_REF : G_MRS;
                     g_load = 1'b1;
                     g_load_val = (cmd == `DSC_CMD_REF) ? RFC_LD : MRD_LD;
                  end
                  else
                     g_ill = 1'b1;
               end
               else if (cmd == `DSC_CMD_RD && (dll_busy || !dll_en))
                  g_ill = 1'b1;
            end
            else if (!cke_prev_r && !is_nop)
               g_ill = 1'b1;
         end
         G_REF, G_MRS, G_XSR:
         begin
            if (!is_nop || !cke)
               g_ill = 1'b1;
            if (g_expire || !g_busy)
               g_nxt = G_RUN;
         end
         G_PPD, G_APD:
         begin
            if (cke)
            begin
               g_nxt = G_RUN;
               if (!is_nop)
                  g_ill = 1'b1;
            end
         end
         G_SREF:
         begin
            if (cke)
            begin
               g_nxt = G_XSR;
               g_load = 1'b1;
               g_load_val = XSNR_LD;
               dll_load = 1'b1;
               if (!is_nop)
                  g_ill = 1'b1;
            end
         end
         default:
         begin
            g_nxt = G_RUN;
         end
      endcase
   end

   always @(posedge mclk)
   begin
      if (srst)
      begin
         g_r <= G_RUN;
         cke_prev_r <= 1'b0;
         dll_en_prev_r <= 1'b0;
         lp_state_r <= `DSC_LP_NONE;
         buf_en_r <= 1'b1;
         cmd_illegal_r <= 1'b0;
         dll_ready_r <= 1'b0;
         last_rd_bank_r <= 2'h0;
      end
      else
      begin
         g_r <= g_nxt;
         cke_prev_r <= cke;
         dll_en_prev_r <= dll_en;
         cmd_illegal_r <= g_ill || (|bk_ill);
         dll_ready_r <= dll_en && !dll_load && (dll_expire || !dll_busy);
         if (|bk_rd)
            last_rd_bank_r <= bank_sel;
         case (g_nxt)
            G_PPD: lp_state_r <= `DSC_LP_PPD;
            G_APD: lp_state_r <= `DSC_LP_APD;
            G_SREF: lp_state_r <= `DSC_LP_SREF;
            default: lp_state_r <= `DSC_LP_NONE;
         endcase
         // Buffers off in any low-power state
         buf_en_r <= !(g_nxt == G_PPD || g_nxt == G_APD ||
            g_nxt == G_SREF);
      end
   end

endmodule

// ===== verif/dsc_cmd_state_assertions.sv
// Checker for the DDR command-state block, on its top ports only.
// Assumes commands change away from the rising edge of mclk.
`timescale 1ns/1ps
module dsc_cmd_state_assertions
(
   input wire mclk,
   input wire srst,
   input wire cke,
   input wire cs_n,
   input wire ras_n,
   input wire cas_n,
   input wire we_n,
   input wire all_banks_select_bit,
   input wire bank_select_bit0,
   input wire bank_select_bit1,
   input wire dll_en,
   input wire [11:0] bank_state,
   input wire [1:0] lp_state_r,
   input wire buf_en_r,
   input wire cmd_illegal_r,
   input wire dll_ready_r,
   input wire [1:0] last_rd_bank_r
);
   reg cke_q;
   wire [3:0] c = {cs_n, ras_n, cas_n, we_n};
   wire idle_cmd = cs_n || c == 4'h7;
   wire [1:0] bsel = {bank_select_bit1, bank_select_bit0};
   wire ok = cke && cke_q && lp_state_r == 2'h0;
   wire fall = cke_q && !cke && lp_state_r == 2'h0;
   wire all_idle = bank_state == 12'h000;
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (srst);
   // Same reset level for the previous clock-enable sample as the block
   always @(posedge mclk)
      cke_q <= srst ? 1'b0 : cke;
   chk_ppd_entry: assert property (fall && idle_cmd && all_idle
      |=> lp_state_r == 2'h1 && !buf_en_r) else $error("ppd entry");
   chk_sref_entry: assert property (fall && c == 4'h1 && all_idle
      |=> lp_state_r == 2'h3) else $error("sref entry");
   chk_lp_hold: assert property (lp_state_r != 2'h0 && !cke
      |=> $stable(lp_state_r) && $stable(bank_state)) else $error("lp hold");
   chk_pd_exit: assert property (lp_state_r inside {2'h1, 2'h2}
      && cke && idle_cmd |=> lp_state_r == 2'h0 && buf_en_r)
      else $error("pd exit");
   chk_nop_keep: assert property (ok && idle_cmd
      && (bank_state & 12'hB6D) == 12'h000 |=> $stable(bank_state))
      else $error("nop changed state");
   chk_act_open: assert property (ok && c == 4'h3 && bsel == 2'h0
      && bank_state[2:0] == 3'h0 |=> bank_state[2:0] == 3'h1 [*2]
      ##1 bank_state[2:0] == 3'h2) else $error("act timing");
   chk_pre_close: assert property (ok && c == 4'h2
      && (all_banks_select_bit || bsel == 2'h0) && bank_state[2:0] == 3'h2
      |=> bank_state[2:0] == 3'h5 [*2] ##1 bank_state[2:0] == 3'h0)
      else $error("pre timing");
   chk_rd_start: assert property (ok && c == 4'h5 && dll_ready_r
      && bank_state[bsel*3 +: 3] == 3'h2 |=> last_rd_bank_r == $past(bsel))
      else $error("read bank");
   cover property (lp_state_r == 2'h2);
   cover property (lp_state_r == 2'h3);
   cover property (cmd_illegal_r);
   cover property (bank_state[2:0] == 3'h6);
endmodule
bind dsc_cmd_state dsc_cmd_state_assertions i_chk
(
   .mclk(mclk), .srst(srst), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
   .cas_n(cas_n), .we_n(we_n), .all_banks_select_bit(all_banks_select_bit),
   .bank_select_bit0(bank_select_bit0), .bank_select_bit1(bank_select_bit1),
   .dll_en(dll_en), .bank_state(bank_state), .lp_state_r(lp_state_r),
   .buf_en_r(buf_en_r), .cmd_illegal_r(cmd_illegal_r),
   .dll_ready_r(dll_ready_r), .last_rd_bank_r(last_rd_bank_r)
);

// ===== verif/dsc_ctl_model.sv
// Memory-controller model that drives the command pins.
// The bench calls put just after a falling edge of mclk.
`timescale 1ns/1ps
`include "dsc_consts.vh"
module dsc_ctl_model
(
   output reg cke,
   output reg cs_n,
   output reg [2:0] strb,
   output reg a10,
   output reg [1:0] ba
);
   initial
   begin
      cke = 1'b1;
      cs_n = 1'b1;
      strb = 3'h7;
      a10 = 1'b0;
      ba = 2'h0;
   end
   task put(input [3:0] c, input [1:0] b, input a, input k);
      reg [5:0] r;
      reg [2:0] s;
      begin
         // Lines a NOP or deselect leaves open keep toggling
         r = 6'($urandom);
         s = r[5:3];
         case (c)
            `DSC_CMD_NOP: s = 3'h7;
            `DSC_CMD_ACT: s = 3'h3;
            `DSC_CMD_RD: s = 3'h5;
            `DSC_CMD_WR: s = 3'h4;
            `DSC_CMD_PRE: s = 3'h2;
            `DSC_CMD_BST: s = 3'h6;
            `DSC_CMD_REF: s = 3'h1;
            `DSC_CMD_MRS: s = 3'h0;
            default: ;
         endcase
         // Each pin is written once per call
         cke = k;
         cs_n = c == `DSC_CMD_DES;
         strb = s;
         a10 = (c > `DSC_CMD_NOP) ? a : r[2];
         ba = (c > `DSC_CMD_NOP) ? b : r[1:0];
      end
   endtask
endmodule

// ===== verif/dsc_cmd_state_tb.sv
// Self-checking bench for the DDR command-state block.
// Drives through the controller model at falling edges of mclk.
`timescale 1ns/1ps
`include "dsc_consts.vh"
module dsc_cmd_state_tb;
   localparam [3:0] C_DES = `DSC_CMD_DES;
   localparam [3:0] C_NOP = `DSC_CMD_NOP;
   localparam [3:0] C_ACT = `DSC_CMD_ACT;
   localparam [3:0] C_RD = `DSC_CMD_RD;
   localparam [3:0] C_WR = `DSC_CMD_WR;
   localparam [3:0] C_PRE = `DSC_CMD_PRE;
   localparam [3:0] C_BST = `DSC_CMD_BST;
   localparam [3:0] C_REF = `DSC_CMD_REF;
   localparam [3:0] C_MRS = `DSC_CMD_MRS;
   reg mclk;
   reg srst;
   reg dll_en;
   wire cke, cs_n, a10, buf_en_r, cmd_illegal_r, dll_ready_r;
   wire [2:0] strb;
   wire [1:0] ba, lp_state_r, last_rd_bank_r;
   wire [11:0] bank_state;
   int n_mismatch = 0;
   int cmp_count = 0;
   int st[4];
   int cn[4];
   int lp, ill, lrb, dok, b, j;
   int pk = 1;
   int dll_on = 0;
   dsc_ctl_model i_ctl
   (
      .cke(cke), .cs_n(cs_n), .strb(strb), .a10(a10), .ba(ba)
   );
   dsc_cmd_state i_dut
   (
      .mclk(mclk), .srst(srst), .cke(cke), .cs_n(cs_n),
      .ras_n(strb[2]), .cas_n(strb[1]), .we_n(strb[0]),
      .all_banks_select_bit(a10), .bank_select_bit0(ba[0]),
      .bank_select_bit1(ba[1]), .dll_en(dll_en),
      .bank_state(bank_state), .lp_state_r(lp_state_r),
      .buf_en_r(buf_en_r), .cmd_illegal_r(cmd_illegal_r),
      .dll_ready_r(dll_ready_r), .last_rd_bank_r(last_rd_bank_r)
   );
   task chk(input [31:0] got, input [31:0] exp);
      begin
         cmp_count++;
         if (got !== exp)
         begin
            n_mismatch++;
            $display("Error t=%0t got=%0h exp=%0h", $time, got, exp);
         end
      end
   endtask
   task wrap_up;
      begin
         $display("compares=%0d mismatches=%0d", cmp_count, n_mismatch);
         if (n_mismatch == 0 && cmp_count > 0)
            $display("RESULT: PASS");
         else
            $display("RESULT: FAIL");
         $finish;
      end
   endtask
   task go(input int i, input int s);
      begin
         st[i] = s;
         cn[i] = (s == 2) ? 0 : 2;
         if (s == 3 || s == 6)
            lrb = i;
      end
   endtask
   // One command edge: drive, let it land, advance the model, compare
   task step(input [3:0] c, input int b, input int a, input int k);
      int i;
      int so[4];
      int bs;
      int any;
      begin
         @(negedge mclk);
         i_ctl.put(c, b[1:0], a[0], k[0]);
         dll_en = dll_on[0];
         @(posedge mclk);
         #1;
         so = st;
         any = so[0] | so[1] | so[2] | so[3];
         ill = 0;
         for (i = 0; i < 4; i++)
         begin
            if (cn[i] == 1)
               st[i] = (so[i] == 5) ? 0 : ((so[i] > 5) ? 5 : 2);
            if (cn[i] > 0)
               cn[i]--;
            // Auto precharge: burst end starts the precharge wait
            if (so[i] > 5 && st[i] == 5)
               cn[i] = 2;
         end
         if (lp != 0)
         begin
            if (k)
               lp = 0;
         end
         else if (!k)
            lp = (c == C_REF) ? 3 : ((any == 0) ? 1 : 2);
         else if (pk)
            case (c)
               C_ACT: if (so[b] == 0) go(b, 1); else ill = 1;
               C_RD:
               begin
                  // Flagged while the loop relocks, burst still starts
                  ill = !dok;
                  if (so[b] inside {2, 3, 4})
                     go(b, a ? 6 : 3);
                  else
                     ill = 1;
               end
               C_WR: if (so[b] inside {2, 4}) go(b, a ? 7 : 4); else ill = 1;
               C_BST: if (so[lrb] == 3) go(lrb, 2); else ill = 1;
               C_REF, C_MRS: ill = (any != 0);
               C_PRE:
                  for (i = 0; i < 4; i++)
                     if (a || i == b)
                        if (so[i] inside {2, 3, 4}) go(i, 5);
                        else if (so[i] != 0) ill = 1;
               default: ;
            endcase
         pk = k;
         bs = st[0] | (st[1] << 3) | (st[2] << 6) | (st[3] << 9);
         chk(bank_state, bs);
         chk(lp_state_r, lp);
         chk(buf_en_r, lp == 0);
         chk(cmd_illegal_r, ill);
         chk(last_rd_bank_r, lrb);
      end
   endtask
   task dll_wait;
      int n;
      begin
         n = 0;
         while (dll_ready_r !== 1'b1 && n < 300)
         begin
            step(C_NOP, 0, 0, 1);
            n++;
         end
         chk(n > 180 && n < 210, 1);
         dok = 1;
         if (n >= 300)
            wrap_up;
      end
   endtask
   initial
   begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   initial
   begin
      srst = 1'b1;
      dll_en = 1'b0;
      void'($urandom(32'h5693));
      repeat (6) @(negedge mclk);
      srst = 1'b0;
      step(C_NOP, 0, 0, 1);
      chk(dll_ready_r, 0);
      step(C_RD, 0, 0, 1);
      step(C_ACT, 0, 0, 1);
      repeat (2) step(C_NOP, 0, 0, 1);
      step(C_RD, 0, 0, 1);
      step(C_PRE, 0, 0, 1);
      dll_on = 1;
      dll_wait;
      for (j = 0; j < 6; j++)
      begin
         b = $urandom % 4;
         step(C_ACT, b, 0, 1);
         step(C_ACT, b, 0, 1);
         step(C_NOP, b, 0, 1);
         step(($urandom % 2) ? C_RD : C_WR, b, 0, 1);
         step(C_RD, b, 0, 1);
         step(C_WR, b, 0, 1);
         step(C_BST, b, 0, 1);
         step(C_RD, b, 0, 1);
         step(C_PRE, b, 0, 1);
         repeat (2) step(C_NOP, b, 0, 1);
      end
      step(C_ACT, 0, 0, 1);
      step(C_ACT, 3, 0, 1);
      repeat (2) step(C_NOP, 0, 0, 1);
      step(C_REF, 0, 0, 1);
      step(C_MRS, 0, 0, 1);
      step(C_PRE, $urandom % 4, 1, 1);
      repeat (2) step(C_NOP, 0, 0, 1);
      step(C_ACT, 1, 0, 1);
      repeat (2) step(C_NOP, 1, 0, 1);
      step(C_NOP, 1, 0, 0);
      repeat (2) step(C_DES, 1, 0, 0);
      step(C_NOP, 1, 0, 1);
      step(C_PRE, 1, 0, 1);
      repeat (2) step(C_NOP, 1, 0, 1);
      step(C_NOP, 0, 0, 0);
      step(C_DES, 0, 0, 0);
      step(C_NOP, 0, 0, 1);
      step(C_REF, 0, 0, 0);
      repeat (2) step(C_DES, 0, 0, 0);
      dok = 0;
      repeat (10) step(C_NOP, 0, 0, 1);
      step(C_ACT, 2, 0, 1);
      repeat (2) step(C_NOP, 2, 0, 1);
      step(C_RD, 2, 0, 1);
      dll_wait;
      step(C_RD, 2, 0, 1);
      step(C_PRE, 2, 0, 1);
      repeat (2) step(C_NOP, 2, 0, 1);
      step(C_MRS, 0, 0, 1);
      repeat (2) step(C_NOP, 0, 0, 1);
      step(C_ACT, 0, 0, 1);
      repeat (2) step(C_NOP, 0, 0, 1);
      step(C_RD, 0, 1, 1);
      step(C_PRE, 0, 0, 1);
      repeat (3) step(C_NOP, 0, 0, 1);
      step(C_ACT, 0, 0, 1);
      repeat (2) step(C_NOP, 0, 0, 1);
      step(C_WR, 0, 1, 1);
      repeat (4) step(C_NOP, 0, 0, 1);
      wrap_up;
   end
endmodule
